// >>> core/gds_fault_supervisor.sv
// Gate driver fault supervisor with AHB-Lite register access
`timescale 1ns/1ps
module gds_fault_supervisor (
    // Clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               sys_rst_in,
    // AHB-Lite slave
    input  wire logic               hsel_in,
    input  wire logic [31:0]        haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    output logic [31:0]             hrdata_out,
    // Analog monitors and sensed bridge outputs
    input  wire gds_pkg::gds_sense_s sense_in,
    input  wire logic [7:0]         vout_level_in,
    // Gate drive
    output gds_pkg::gds_drive_s     drive_out
);
    import gds_pkg::*;

    // Selector field of one timing pair from a packed group of four
    function automatic logic [SEL_W-1:0] pick_sel(input logic [PAIR_NUM*SEL_W-1:0] grp,
                                                  input logic [MAP_W-1:0] pair);
        pick_sel = grp[SEL_W*pair +: SEL_W];
    endfunction : pick_sel

    function automatic gds_cnt_t blank_cyc(input logic [SEL_W-1:0] sel);
        blank_cyc = gds_ns_to_cyc(BLANK_NS[sel]);
    endfunction : blank_cyc

    function automatic gds_cnt_t ccp_cyc(input logic [SEL_W-1:0] sel);
        ccp_cyc = gds_ns_to_cyc(CCP_NS[sel]);
    endfunction : ccp_cyc

    function automatic logic mode_is_off(input logic [1:0] m);
        mode_is_off = (m == MODE_OFF0) || (m == MODE_OFF3);
    endfunction : mode_is_off

    // Configuration registers
    logic [CTRL_W-1:0]         ctrl_q;
    logic [HB_NUM*2-1:0]       mode_q;
    logic [PAIR_NUM*SEL_W-1:0] act_blk_q;
    logic [PAIR_NUM*SEL_W-1:0] fw_blk_q;
    logic [PAIR_NUM*SEL_W-1:0] act_ccp_q;
    logic [PAIR_NUM*SEL_W-1:0] fw_ccp_q;
    logic [HB_NUM*MAP_W-1:0]   map_q;
    logic [HB_NUM-1:0]         diag_en_q;
    // Status and fault state
    logic [GS_W-1:0]           gstat_q, gstat_d;
    logic                      ov_pump_off_q, ov_pump_off_d;
    // Bus pipeline
    logic                      wr_pend_q;
    logic                      rd_pend_q;
    logic [7:0]                addr_q;
    logic [31:0]               rdata_q;

    // Bus decode
    wire        addr_phase  = hsel_in && htrans_in[1] && hready_in;
    wire        wr_en       = wr_pend_q;
    wire        gstat_clear = wr_en && (addr_q == ADDR_GENERAL_STATUS_REGISTER);
    wire        passive     = ctrl_q[CTRL_PASS_BIT];
    wire        ov_sel      = ctrl_q[CTRL_OVTH_BIT];

    // Fault conditions
    wire        ov_trip     = ov_sel ? sense_in.vs_above_ov_off2 : sense_in.vs_above_ov_off1;
    wire        ov_event    = ov_trip && !passive;
    wire        uv_event    = sense_in.vs_below_uv_off;
    wire        tsd_event   = sense_in.temp_sd;
    // Drivers stay off while the TSD, supply under or supply over flag is latched; warning, pump and supply error flags are not among them
    wire        force_off   = gstat_q[GS_TSD] || gstat_q[GS_SUPPLY_UNDER_FLAG] || gstat_q[GS_SUPPLY_OVER_FLAG];

    // Read-back values
    logic [HB_NUM-1:0] vout_status;
    logic [31:0]       rd_mux;

    // Flag set/clear; a set in the clear cycle wins
    always_comb begin
        gstat_d       = gstat_q;
        ov_pump_off_d = ov_pump_off_q;
        if (gstat_clear) begin
            if (!sense_in.temp_warn) begin
                gstat_d[GS_TW] = 1'b0;
            end
            if (!sense_in.temp_sd) begin
                gstat_d[GS_TSD] = 1'b0;
            end
            if (sense_in.vs_above_uv_on) begin
                gstat_d[GS_SUPPLY_UNDER_FLAG] = 1'b0;
            end
            if (sense_in.vs_below_ov_on) begin
                gstat_d[GS_SUPPLY_OVER_FLAG] = 1'b0;
            end
            if (!sense_in.cp_under) begin
                gstat_d[GS_PUMP_UNDERVOLTAGE_FLAG] = 1'b0;
            end
        end
        // Supply error stays while any supply class flag remains
        if (gstat_clear && !gstat_d[GS_TSD] && !gstat_d[GS_SUPPLY_UNDER_FLAG] && !gstat_d[GS_SUPPLY_OVER_FLAG] && !gstat_d[GS_PUMP_UNDERVOLTAGE_FLAG]) begin
            gstat_d[GS_SUPPLY_ERROR_FLAG] = 1'b0;
        end
        if (sense_in.temp_warn) begin
            gstat_d[GS_TW] = 1'b1;
        end
        if (tsd_event) begin
            gstat_d[GS_TSD]  = 1'b1;
            gstat_d[GS_SUPPLY_ERROR_FLAG] = 1'b1;
            gstat_d[GS_PUMP_UNDERVOLTAGE_FLAG] = 1'b1;
        end
        if (uv_event) begin
            gstat_d[GS_SUPPLY_UNDER_FLAG] = 1'b1;
            gstat_d[GS_SUPPLY_ERROR_FLAG] = 1'b1;
            gstat_d[GS_PUMP_UNDERVOLTAGE_FLAG] = 1'b1;
        end
        if (ov_event) begin
            gstat_d[GS_SUPPLY_OVER_FLAG] = 1'b1;
            gstat_d[GS_SUPPLY_ERROR_FLAG] = 1'b1;
            gstat_d[GS_PUMP_UNDERVOLTAGE_FLAG] = 1'b1;
            ov_pump_off_d    = 1'b1;
        end else if (sense_in.vs_below_ov_on) begin
            // Pump restart needs no software; the flag still holds the FETs off
            ov_pump_off_d = 1'b0;
        end
        if (sense_in.cp_under) begin
            gstat_d[GS_PUMP_UNDERVOLTAGE_FLAG] = 1'b1;
            gstat_d[GS_SUPPLY_ERROR_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gstat_q       <= '0;
            ov_pump_off_q <= 1'b0;
        end else begin
            gstat_q       <= gstat_d;
            ov_pump_off_q <= ov_pump_off_d;
        end
    end

    // Configuration is reset only by the logic reset, never by a supply fault
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_q    <= CTRL_RST;
            mode_q    <= MODE_RST;
            act_blk_q <= SEL_RST;
            fw_blk_q  <= SEL_RST;
            act_ccp_q <= SEL_RST;
            fw_ccp_q  <= SEL_RST;
            map_q     <= MAP_RST;
            diag_en_q <= '0;
        end else if (wr_en) begin
            case (addr_q)
                ADDR_CTRL:     ctrl_q    <= hwdata_in[CTRL_W-1:0];
                ADDR_MODE:     mode_q    <= hwdata_in[HB_NUM*2-1:0];
                ADDR_ACT_BLK:  act_blk_q <= hwdata_in[PAIR_NUM*SEL_W-1:0];
                ADDR_FW_BLK:   fw_blk_q  <= hwdata_in[PAIR_NUM*SEL_W-1:0];
                ADDR_ACT_CCP:  act_ccp_q <= hwdata_in[PAIR_NUM*SEL_W-1:0];
                ADDR_FW_CCP:   fw_ccp_q  <= hwdata_in[PAIR_NUM*SEL_W-1:0];
                ADDR_PAIR_MAP: map_q     <= hwdata_in[HB_NUM*MAP_W-1:0];
                ADDR_DIAG_EN:  diag_en_q <= hwdata_in[HB_NUM-1:0];
                default:       ctrl_q    <= ctrl_q;
            endcase
        end
    end

    // Per-bridge sequencing, diagnostics and read-back
    genvar gi;
    generate
        for (gi = 0; gi < HB_NUM; gi++) begin : g_hb
            wire [1:0]       hb_mode = mode_q[2*gi +: 2];
            wire [MAP_W-1:0] pair    = map_q[MAP_W*gi +: MAP_W];

            gds_hb_timer u_timer (
                .core_clk_in (core_clk_in),
                .sys_rst_in  (sys_rst_in),
                .mode_in     (hb_mode),
                .enable_in   (!force_off),
                .ccp_act_in  (ccp_cyc(pick_sel(act_ccp_q, pair))),
                .ccp_fw_in   (ccp_cyc(pick_sel(fw_ccp_q, pair))),
                .blk_act_in  (blank_cyc(pick_sel(act_blk_q, pair))),
                .blk_fw_in   (blank_cyc(pick_sel(fw_blk_q, pair))),
                .hs_on_out   (drive_out.hs_on[gi]),
                .ls_on_out   (drive_out.ls_on[gi]),
                .blank_out   (drive_out.vds_blank[gi])
            );

            assign drive_out.diag_pulldown[gi] = diag_en_q[gi] && !passive && mode_is_off(hb_mode);
            assign vout_status[gi] = mode_is_off(hb_mode) ? vout_level_in[gi] : 1'b0;
        end
    endgenerate

    assign drive_out.diag_pullup       = !passive;
    assign drive_out.static_discharge  = force_off;
    assign drive_out.discharge_setting = ctrl_q[CTRL_ICHG_LSB +: ICHG_W];
    assign drive_out.pump_enable       = !gstat_q[GS_TSD] && !gstat_q[GS_SUPPLY_UNDER_FLAG] && !ov_pump_off_q;

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_q)
            ADDR_CTRL:     rd_mux[CTRL_W-1:0]         = ctrl_q;
            ADDR_MODE:     rd_mux[HB_NUM*2-1:0]       = mode_q;
            ADDR_ACT_BLK:  rd_mux[PAIR_NUM*SEL_W-1:0] = act_blk_q;
            ADDR_FW_BLK:   rd_mux[PAIR_NUM*SEL_W-1:0] = fw_blk_q;
            ADDR_ACT_CCP:  rd_mux[PAIR_NUM*SEL_W-1:0] = act_ccp_q;
            ADDR_FW_CCP:   rd_mux[PAIR_NUM*SEL_W-1:0] = fw_ccp_q;
            ADDR_PAIR_MAP: rd_mux[HB_NUM*MAP_W-1:0]   = map_q;
            ADDR_DIAG_EN:  rd_mux[HB_NUM-1:0]         = diag_en_q;
            ADDR_VOUT:     rd_mux[HB_NUM-1:0]         = vout_status;
            ADDR_GENERAL_STATUS_REGISTER:  rd_mux[GS_W-1:0]           = gstat_q;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state so a write just before is always seen
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end else begin
            if (addr_phase) begin
                addr_q <= haddr_in[7:0];
            end
            wr_pend_q <= addr_phase && hwrite_in;
            rd_pend_q <= addr_phase && !hwrite_in;
            if (rd_pend_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign hreadyout_out = !rd_pend_q;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_q;

endmodule : gds_fault_supervisor

// >>> core/gds_pkg.sv
// Shared constants and types for the gate driver fault supervisor
package gds_pkg;

    // Clock rate and counter sizing
    localparam int CLK_MHZ      = 40;
    localparam int NS_PER_US    = 1000;
    localparam int HB_NUM       = 8;
    localparam int PAIR_NUM     = 4;
    localparam int SEL_W        = 3;
    localparam int MAP_W        = 2;
    localparam int CNT_W        = 10;

    typedef logic [CNT_W-1:0] gds_cnt_t;
    localparam gds_cnt_t CNT_ONE = 10'h001;

    // Least time in ns to whole clock cycles, rounded up
    function automatic gds_cnt_t gds_ns_to_cyc(input int ns);
        gds_ns_to_cyc = CNT_W'((ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    endfunction : gds_ns_to_cyc

    // Typical blank times, selector 000 to 111
    localparam int BLANK_NS [0:7] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};
    // Typical cross-current protection times, selector 000 to 111
    localparam int CCP_NS   [0:7] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};

    // Half-bridge mode field encodings
    localparam logic [1:0] MODE_OFF0 = 2'h0;
    localparam logic [1:0] MODE_LS   = 2'h1;
    localparam logic [1:0] MODE_HS   = 2'h2;
    localparam logic [1:0] MODE_OFF3 = 2'h3;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_MODE     = 8'h04;
    localparam logic [7:0] ADDR_ACT_BLK  = 8'h08;
    localparam logic [7:0] ADDR_FW_BLK   = 8'h0C;
    localparam logic [7:0] ADDR_ACT_CCP  = 8'h10;
    localparam logic [7:0] ADDR_FW_CCP   = 8'h14;
    localparam logic [7:0] ADDR_PAIR_MAP = 8'h18;
    localparam logic [7:0] ADDR_DIAG_EN  = 8'h1C;
    localparam logic [7:0] ADDR_VOUT     = 8'h20;
    localparam logic [7:0] ADDR_GENERAL_STATUS_REGISTER  = 8'h24;

    // Control register fields
    localparam int CTRL_PASS_BIT = 0;
    localparam int CTRL_OVTH_BIT = 1;
    localparam int CTRL_ICHG_LSB = 2;
    localparam int ICHG_W        = 3;
    localparam int CTRL_W        = 5;

    // General status register fields
    localparam int GS_TW   = 0;
    localparam int GS_TSD  = 1;
    localparam int GS_SUPPLY_UNDER_FLAG = 2;
    localparam int GS_SUPPLY_OVER_FLAG = 3;
    localparam int GS_PUMP_UNDERVOLTAGE_FLAG = 4;
    localparam int GS_SUPPLY_ERROR_FLAG = 5;
    localparam int GS_W    = 6;

    // Reset values
    localparam logic [CTRL_W-1:0]         CTRL_RST = 5'h00;
    localparam logic [PAIR_NUM*SEL_W-1:0] SEL_RST  = 12'h924;
    localparam logic [HB_NUM*MAP_W-1:0]   MAP_RST  = 16'h0000;
    localparam logic [HB_NUM*2-1:0]       MODE_RST = 16'h0000;

    // Analog comparator outputs from the supply and temperature monitors
    typedef struct packed {
        logic temp_warn;
        logic temp_sd;
        logic vs_below_uv_off;
        logic vs_above_uv_on;
        logic vs_above_ov_off1;
        logic vs_above_ov_off2;
        logic vs_below_ov_on;
        logic cp_under;
    } gds_sense_s;

    // Gate drive commands to the eight half-bridges
    typedef struct packed {
        logic [HB_NUM-1:0]   hs_on;
        logic [HB_NUM-1:0]   ls_on;
        logic [HB_NUM-1:0]   vds_blank;
        logic [HB_NUM-1:0]   diag_pulldown;
        logic                diag_pullup;
        logic                static_discharge;
        logic [ICHG_W-1:0]   discharge_setting;
        logic                pump_enable;
    } gds_drive_s;

    typedef enum logic [1:0] {HB_OFF, HB_CCP, HB_BLANK, HB_ON} gds_hb_e;

endpackage : gds_pkg

// >>> core/gds_hb_timer.sv
// One half-bridge: cross-current dead time and drain-source blank sequencing
`timescale 1ns/1ps
module gds_hb_timer (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    // Requested state and timing in cycles
    input  wire logic [1:0]       mode_in,
    input  wire logic             enable_in,
    input  wire gds_pkg::gds_cnt_t ccp_act_in,
    input  wire gds_pkg::gds_cnt_t ccp_fw_in,
    input  wire gds_pkg::gds_cnt_t blk_act_in,
    input  wire gds_pkg::gds_cnt_t blk_fw_in,
    // Gate commands
    output logic                  hs_on_out,
    output logic                  ls_on_out,
    output logic                  blank_out
);
    import gds_pkg::*;

    gds_hb_e    st_q, st_d;
    logic [1:0] drv_q, drv_d;
    gds_cnt_t   cnt_q, cnt_d;
    logic [1:0] tgt;
    gds_cnt_t   blk_tgt;
    gds_cnt_t   ccp_cur;

    // High side is the active FET, low side the free-wheeling one
    assign tgt     = (enable_in && (mode_in == MODE_LS || mode_in == MODE_HS)) ? mode_in : MODE_OFF0;
    assign blk_tgt = (tgt == MODE_HS) ? blk_act_in : blk_fw_in;
    assign ccp_cur = (drv_q == MODE_HS) ? ccp_act_in : ccp_fw_in;

    always_comb begin
        st_d  = st_q;
        drv_d = drv_q;
        cnt_d = cnt_q;
        case (st_q)
            HB_OFF: begin
                // Turn-on from high impedance blanks at once
                if (tgt != MODE_OFF0) begin
                    drv_d = tgt;
                    cnt_d = blk_tgt;
                    st_d  = HB_BLANK;
                end
            end
            HB_CCP: begin
                if (cnt_q <= CNT_ONE) begin
                    if (tgt != MODE_OFF0) begin
                        drv_d = tgt;
                        cnt_d = blk_tgt;
                        st_d  = HB_BLANK;
                    end else begin
                        st_d = HB_OFF;
                    end
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            HB_BLANK, HB_ON: begin
                if (tgt != drv_q) begin
                    // Both FETs stay off for the dead time of the one leaving
                    drv_d = MODE_OFF0;
                    cnt_d = ccp_cur;
                    st_d  = HB_CCP;
                end else if (st_q == HB_BLANK) begin
                    if (cnt_q <= CNT_ONE) begin
                        st_d = HB_ON;
                    end else begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
            end
            default: begin
                st_d  = HB_OFF;
                drv_d = MODE_OFF0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q  <= HB_OFF;
            drv_q <= MODE_OFF0;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            drv_q <= drv_d;
            cnt_q <= cnt_d;
        end
    end

    assign hs_on_out = (drv_q == MODE_HS);
    assign ls_on_out = (drv_q == MODE_LS);
    assign blank_out = (st_q == HB_BLANK);

endmodule : gds_hb_timer

// >>> testbench/gds_fault_supervisor_asserts.sv
// Port-level checks on the gate driver fault supervisor
`timescale 1ns/1ps
module gds_fault_supervisor_asserts (
    // Clock and reset
    input wire logic                core_clk_in,
    input wire logic                sys_rst_in,
    // Bus handshake
    input wire logic                hsel_in,
    input wire logic [1:0]          htrans_in,
    input wire logic                hwrite_in,
    input wire logic                hready_in,
    input wire logic                hreadyout_out,
    // Monitors and gate drive
    input wire gds_pkg::gds_sense_s sense_in,
    input wire gds_pkg::gds_drive_s drive_out
);
    import gds_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic [7:0] on_w = drive_out.hs_on | drive_out.ls_on;
    wire logic [7:0] hs_w = drive_out.hs_on;
    wire logic [7:0] ls_w = drive_out.ls_on;
    wire logic take_w = hsel_in & htrans_in[1] & hready_in;

    AST_BLANK_ON: assert property ((on_w & ~$past(on_w) & ~drive_out.vds_blank) == 8'h00)
        else $error("gate turned on without blank");
    AST_NO_OVERLAP: assert property (((hs_w & (ls_w | $past(ls_w))) | (ls_w & $past(hs_w))) == 8'h00)
        else $error("both FETs of one bridge on");
    AST_TSD_OFF: assert property (sense_in.temp_sd [*4] |-> on_w == 8'h00)
        else $error("gates on during thermal shutdown");
    AST_TSD_PUMP: assert property (sense_in.temp_sd [*3] |-> !drive_out.pump_enable)
        else $error("pump running during thermal shutdown");
    AST_UV_OFF: assert property (sense_in.vs_below_uv_off [*4] |-> on_w == 8'h00 && drive_out.static_discharge)
        else $error("gates on during undervoltage");
    AST_DISCHARGE: assert property (drive_out.static_discharge [*3] |-> on_w == 8'h00)
        else $error("gates on while discharging");
    AST_READ_WAIT: assert property (take_w && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (take_w && hwrite_in |=> hreadyout_out)
        else $error("write stalled");
endmodule : gds_fault_supervisor_asserts

bind gds_fault_supervisor gds_fault_supervisor_asserts gds_fault_supervisor_asserts_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
    .sense_in(sense_in), .drive_out(drive_out));

// >>> testbench/gds_mcu.sv
// Bus master model of the configuring controller
`timescale 1ns/1ps
module gds_mcu (
    // Clock and bus answer
    input  wire logic        core_clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    // Bus request
    output logic             hsel_out = 1'h0,
    output logic [31:0]      haddr_out = 32'h0000_0000,
    output logic [1:0]       htrans_out = 2'h0,
    output logic             hwrite_out = 1'h0,
    output logic [31:0]      hwdata_out = 32'h0000_0000
);
    // Diagnostic threshold settings are the caller's job, sent as ordinary writes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        logic r;
        @(posedge core_clk_in);
        hsel_out <= 1'h1;
        haddr_out <= {24'h00_0000, a};
        htrans_out <= 2'h2;
        hwrite_out <= w;
        do begin
            @(negedge core_clk_in);
            r = hready_in;
            @(posedge core_clk_in);
        end while (r !== 1'h1);
        hsel_out <= 1'h0;
        htrans_out <= 2'h0;
        hwdata_out <= d;
        do begin
            @(negedge core_clk_in);
            r = hready_in;
            q = hrdata_in;
            @(posedge core_clk_in);
        end while (r !== 1'h1);
    endtask : xfer
endmodule : gds_mcu

// >>> testbench/gds_fault_supervisor_tb_top.sv
// Self-checking bench for the gate driver fault supervisor
`timescale 1ns/1ps
module gds_fault_supervisor_tb_top;
    import gds_pkg::*;
    // Idle monitors: supply between both on levels, no fault
    localparam gds_sense_s IDLE = 8'h12;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic hsel, hwrite, hready, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] vout = 8'h00;
    gds_sense_s sense = IDLE;
    gds_drive_s drv;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;
    // A stopped pump lets its output sag, so the monitor follows it
    always @(posedge clk) sense.cp_under <= ~drv.pump_enable;

    gds_fault_supervisor gds_fault_supervisor_inst (
        .core_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .sense_in(sense),
        .vout_level_in(vout), .drive_out(drv));
    gds_mcu gds_mcu_inst (
        .core_clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));

    task automatic stop_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        gds_mcu_inst.xfer(1'h1, a, d, q);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        gds_mcu_inst.xfer(1'h0, a, 32'h0000_0000, q);
        chk($sformatf("register %h", a), e, q);
        chk("hresp", 32'h0000_0000, 32'(hresp));
    endtask : rchk

    // Settle past the edge so registered outputs are compared after they land
    task automatic cw(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cw

    task automatic sn(input gds_sense_s v, input int n);
        @(posedge clk);
        sense[7:1] <= v[7:1];
        cw(n);
    endtask : sn

    task automatic clr2();
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        cw(3);
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
    endtask : clr2

    function automatic int bc(input int c);
        return (BLANK_NS[c] * CLK_MHZ + 999) / 1000;
    endfunction : bc

    task automatic blank(input int b, input logic [1:0] m, input int e);
        int n;
        n = 0;
        wr(ADDR_MODE, 32'(m) << (2 * b));
        while (drv.vds_blank[b] !== 1'h1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (drv.vds_blank[b] === 1'h1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("blank cycles", 32'(e), 32'(n));
        wr(ADDR_MODE, 32'h0000_0000);
        cw(700);
    endtask : blank

    task automatic t_regs();
        rchk(ADDR_ACT_BLK, 32'h0000_0924);
        rchk(ADDR_FW_BLK, 32'h0000_0924);
        rchk(ADDR_PAIR_MAP, 32'h0000_0000);
        rchk(8'h40, 32'h0000_0000);
        wr(ADDR_VOUT, 32'h0000_00FF);
        rchk(ADDR_VOUT, 32'h0000_0000);
    endtask : t_regs

    task automatic t_blank();
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_ACT_BLK, 32'(c));
            blank(0, MODE_HS, bc(c));
        end
        wr(ADDR_FW_BLK, 32'h0000_0000);
        blank(0, MODE_LS, bc(0));
        wr(ADDR_ACT_BLK, 32'h0000_08D1);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_PAIR_MAP, 32'(p) << 2);
            blank(1, MODE_HS, bc(p + 1));
        end
    endtask : t_blank

    task automatic t_warn();
        wr(ADDR_MODE, 32'h0000_0002);
        sn(8'h92, 120);
        chk("hs on", 32'h0000_0001, 32'(drv.hs_on));
        chk("pump", 32'h0000_0001, 32'(drv.pump_enable));
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0001);
        sn(IDLE, 3);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0001);
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
    endtask : t_warn

    task automatic t_tsd();
        wr(ADDR_CTRL, 32'h0000_0014);
        sn(8'h52, 4);
        chk("hs on", 32'h0000_0000, 32'(drv.hs_on));
        chk("pump", 32'h0000_0000, 32'(drv.pump_enable));
        chk("discharge", 32'h0000_000D, 32'({drv.static_discharge, drv.discharge_setting}));
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0032);
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0032);
        sn(IDLE, 4);
        chk("hs on", 32'h0000_0000, 32'(drv.hs_on));
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        cw(120);
        chk("hs on", 32'h0000_0001, 32'(drv.hs_on));
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
    endtask : t_tsd

    task automatic t_uv();
        sn(8'h22, 4);
        chk("hs on", 32'h0000_0000, 32'(drv.hs_on));
        chk("discharge", 32'h0000_0001, 32'(drv.static_discharge));
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0034);
        sn(8'h02, 3);
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0034);
        rchk(ADDR_MODE, 32'h0000_0002);
        rchk(ADDR_CTRL, 32'h0000_0014);
        sn(IDLE, 3);
        clr2();
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        cw(120);
        chk("hs on", 32'h0000_0001, 32'(drv.hs_on));
    endtask : t_uv

    task automatic t_ov();
        sn(8'h14, 3);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        sn(8'h18, 4);
        chk("hs on", 32'h0000_0000, 32'(drv.hs_on));
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0038);
        sn(8'h10, 3);
        chk("pump", 32'h0000_0000, 32'(drv.pump_enable));
        wr(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0038);
        sn(IDLE, 3);
        chk("pump", 32'h0000_0001, 32'(drv.pump_enable));
        chk("hs on", 32'h0000_0000, 32'(drv.hs_on));
        clr2();
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0016);
        sn(8'h14, 4);
        rchk(ADDR_GENERAL_STATUS_REGISTER, 32'h0000_0038);
        sn(IDLE, 3);
        clr2();
    endtask : t_ov

    task automatic t_diag();
        wr(ADDR_MODE, 32'h0000_001E);
        vout <= 8'hFF;
        rchk(ADDR_VOUT, 32'h0000_00FA);
        wr(ADDR_DIAG_EN, 32'h0000_0006);
        cw(2);
        chk("pulldown", 32'h0000_0002, 32'(drv.diag_pulldown));
        chk("ls on", 32'h0000_0004, 32'(drv.ls_on));
        chk("pullup", 32'h0000_0001, 32'(drv.diag_pullup));
        wr(ADDR_DIAG_EN, 32'h0000_00FF);
        cw(2);
        chk("pulldown", 32'h0000_00FA, 32'(drv.diag_pulldown));
        wr(ADDR_CTRL, 32'h0000_0015);
        cw(2);
        chk("pulldown", 32'h0000_0000, 32'(drv.diag_pulldown));
        chk("pullup", 32'h0000_0000, 32'(drv.diag_pullup));
    endtask : t_diag

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_blank();
        t_warn();
        t_tsd();
        t_uv();
        t_ov();
        t_diag();
        stop_test();
    end
endmodule : gds_fault_supervisor_tb_top
